// ==== rtl/dcc_pkg.sv ====
package dcc_pkg;

    localparam int          ADDR_W = 8;
    localparam int          DATA_W = 32;

    // Register offsets (byte addresses)
    localparam logic [7:0]  OFF_CONFIG_WORD_TWO = 8'h00;
    localparam logic [7:0]  OFF_CONFIG_CONTROL  = 8'h04;
    localparam logic [7:0]  OFF_UNLOCK_KEY      = 8'h08;
    localparam logic [7:0]  OFF_STATUS          = 8'h0C;

    // config_word_two field positions
    localparam int          WORD_USB_PLL_SEL_BIT = 30;
    localparam int          WORD_DEEP_SLEEP_BIT  = 28;
    localparam int          WORD_WDOG_EN_BIT     = 27;
    localparam int          WORD_WDOG_CLK_BIT    = 26;

    // config_control field positions
    localparam int          CTRL_CHARGE_PUMP_BIT = 7;
    localparam int          CTRL_ECC_LSB         = 4;
    localparam int          CTRL_DEBUG_BIT       = 3;
    localparam int          CTRL_TRACE_BIT       = 2;
    localparam int          CTRL_TDO_BIT         = 0;
    localparam logic [31:0] CTRL_WRITE_MASK      = 32'h0000_00BD;

    // status register field positions
    localparam int          STAT_UNLOCKED_BIT = 0;
    localparam int          STAT_FUSE_BIT     = 1;
    localparam int          STAT_LOADED_BIT   = 2;

    // Values after reset
    localparam logic [31:0] CONFIG_WORD_RESET    = 32'hFFFF_FFFF;
    localparam logic [31:0] CONFIG_CONTROL_RESET = 32'h0000_0038;

    // Unlock keys, written in this order; the values are arbitrary
    localparam logic [31:0] UNLOCK_KEY_ONE = 32'h1111_1111;
    localparam logic [31:0] UNLOCK_KEY_TWO = 32'h2222_2222;

    // Flash ECC field encodings
    localparam logic [1:0]  ECC_OFF_OPEN   = 2'h3;
    localparam logic [1:0]  ECC_OFF_LOCKED = 2'h2;
    localparam logic [1:0]  ECC_DYNAMIC    = 2'h1;
    localparam logic [1:0]  ECC_FULL       = 2'h0;

    typedef enum logic [1:0] {
        UNLOCK_IDLE = 2'b00,
        UNLOCK_HALF = 2'b01,
        UNLOCK_OPEN = 2'b11
    } unlock_state_t;

    typedef struct packed {
        logic [7:0]  addr;
        logic [31:0] wdata;
        logic        wr;
        logic        rd;
    } bus_req_t;

    function automatic logic ecc_is_writable(input logic [1:0] field);
        return field == ECC_OFF_OPEN;
    endfunction

endpackage

// ==== rtl/unlock_sequencer.sv ====
`timescale 1ns/1ps
`default_nettype none

module unlock_sequencer
    import dcc_pkg::*;
(
    // Clock and reset
    input  wire logic        clock,
    input  wire logic        resetn,
    // Key writes and consumption
    input  wire logic        key_write,
    input  wire logic [31:0] key_value,
    input  wire logic        consume,
    // Status
    output logic             open
);

    unlock_state_t state_q;
    unlock_state_t state_d;

    // Any wrong key or a config_control write between keys starts over
    always_comb begin
        state_d = state_q;
        case (state_q)
            UNLOCK_IDLE: begin
                if (key_write && key_value == UNLOCK_KEY_ONE) begin
                    state_d = UNLOCK_HALF;
                end
            end
            UNLOCK_HALF: begin
                if (key_write && key_value == UNLOCK_KEY_TWO) begin
                    state_d = UNLOCK_OPEN;
                end else if (key_write || consume) begin
                    state_d = UNLOCK_IDLE;
                end
            end
            UNLOCK_OPEN: begin
                if (consume || key_write) begin
                    state_d = UNLOCK_IDLE;
                end
            end
            default: state_d = UNLOCK_IDLE;
        endcase
    end

    always_ff @(posedge clock) begin
        if (!resetn) begin
            state_q <= UNLOCK_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    assign open = (state_q == UNLOCK_OPEN);

endmodule

`default_nettype wire

// ==== rtl/device_config_control.sv ====
`timescale 1ns/1ps
`default_nettype none

module device_config_control
    import dcc_pkg::*;
(
    // Clock and reset
    input  wire logic        clock,
    input  wire logic        resetn,
    // Register port
    input  wire logic [7:0]  reg_addr,
    input  wire logic [31:0] reg_wdata,
    input  wire logic        reg_write,
    input  wire logic        reg_read,
    output logic      [31:0] reg_rdata,
    // Programmed configuration source
    input  wire logic [31:0] config_word_in,
    input  wire logic        debug_fuse_in,
    // Core power state
    input  wire logic        wait_executed,
    input  wire logic        deep_sleep_active,
    // Clock and power controls
    output logic             usb_pll_input_24mhz,
    output logic             deep_sleep_enter,
    output logic             sleep_enter,
    output logic             deep_sleep_watchdog_run,
    output logic             deep_sleep_watchdog_rc_clock,
    output logic             io_charge_pump_on,
    // Flash ECC controls
    output logic             flash_ecc_on,
    output logic             flash_dynamic_ecc_on,
    output logic             flash_word_write_block,
    // Debug and trace controls
    output logic             debug_port_on,
    output logic             trace_outputs_on,
    output logic             trace_clock_run,
    output logic             two_wire_tdo_use
);

    bus_req_t    req;
    logic [31:0] word_q;
    logic [31:0] ctrl_q;
    logic [31:0] ctrl_d;
    logic        fuse_q;
    logic        loaded_q;
    logic        unlocked;
    logic        ctrl_write;
    logic        key_write;
    logic [1:0]  ecc_field;

    assign req        = '{addr: reg_addr, wdata: reg_wdata, wr: reg_write, rd: reg_read};
    assign ctrl_write = req.wr && req.addr == OFF_CONFIG_CONTROL;
    assign key_write  = req.wr && req.addr == OFF_UNLOCK_KEY;
    assign ecc_field  = ctrl_q[CTRL_ECC_LSB +: 2];

    unlock_sequencer u_unlock (
        .clock     (clock),
        .resetn    (resetn),
        .key_write (key_write),
        .key_value (req.wdata),
        .consume   (ctrl_write),
        .open      (unlocked)
    );

    // Straps are caught one cycle after release, never under reset itself
    always_ff @(posedge clock) begin
        if (!resetn) begin
            word_q   <= CONFIG_WORD_RESET;
            fuse_q   <= 1'b0;
            loaded_q <= 1'b0;
        end else if (!loaded_q) begin
            word_q   <= config_word_in;
            fuse_q   <= debug_fuse_in;
            loaded_q <= 1'b1;
        end
    end

    // Software writes to the config word fall through with no effect
    always_comb begin
        ctrl_d = (ctrl_q & ~CTRL_WRITE_MASK) | (req.wdata & CTRL_WRITE_MASK);
        if (!ecc_is_writable(ecc_field)) begin
            ctrl_d[CTRL_ECC_LSB +: 2] = ecc_field;
        end
        if (!unlocked) begin
            ctrl_d[CTRL_DEBUG_BIT] = ctrl_q[CTRL_DEBUG_BIT];
        end
    end

    always_ff @(posedge clock) begin
        if (!resetn) begin
            ctrl_q <= CONFIG_CONTROL_RESET;
        end else if (ctrl_write) begin
            ctrl_q <= ctrl_d;
        end
    end

    // Read data stands for exactly the cycle after the strobe
    always_ff @(posedge clock) begin
        if (!resetn) begin
            reg_rdata <= 32'h0000_0000;
        end else if (req.rd) begin
            case (req.addr)
                OFF_CONFIG_WORD_TWO: reg_rdata <= word_q;
                OFF_CONFIG_CONTROL:  reg_rdata <= ctrl_q;
                OFF_STATUS: begin
                    reg_rdata                    <= 32'h0000_0000;
                    reg_rdata[STAT_UNLOCKED_BIT] <= unlocked;
                    reg_rdata[STAT_FUSE_BIT]     <= fuse_q;
                    reg_rdata[STAT_LOADED_BIT]   <= loaded_q;
                end
                default: reg_rdata <= 32'h0000_0000;
            endcase
        end else begin
            reg_rdata <= 32'h0000_0000;
        end
    end

    // Clock and power controls from the config word
    always_ff @(posedge clock) begin
        if (!resetn) begin
            usb_pll_input_24mhz          <= 1'b0;
            deep_sleep_watchdog_rc_clock <= 1'b0;
            deep_sleep_watchdog_run      <= 1'b0;
        end else begin
            usb_pll_input_24mhz          <= word_q[WORD_USB_PLL_SEL_BIT];
            deep_sleep_watchdog_rc_clock <= word_q[WORD_WDOG_CLK_BIT];
            deep_sleep_watchdog_run      <= deep_sleep_active
                                            && word_q[WORD_WDOG_EN_BIT];
        end
    end

    // WAIT is steered to one of the two sleep entries, one-cycle pulses
    always_ff @(posedge clock) begin
        if (!resetn) begin
            deep_sleep_enter <= 1'b0;
            sleep_enter      <= 1'b0;
        end else begin
            deep_sleep_enter <= wait_executed && word_q[WORD_DEEP_SLEEP_BIT];
            sleep_enter      <= wait_executed && !word_q[WORD_DEEP_SLEEP_BIT];
        end
    end

    // Run-time controls from config_control
    always_ff @(posedge clock) begin
        if (!resetn) begin
            io_charge_pump_on <= 1'b0;
            debug_port_on     <= 1'b0;
            trace_outputs_on  <= 1'b0;
            trace_clock_run   <= 1'b0;
            two_wire_tdo_use  <= 1'b0;
        end else begin
            io_charge_pump_on <= ctrl_q[CTRL_CHARGE_PUMP_BIT];
            // Fuse is only valid once loaded, so debug stays off until then
            debug_port_on     <= ctrl_q[CTRL_DEBUG_BIT] && fuse_q;
            trace_outputs_on  <= ctrl_q[CTRL_TRACE_BIT];
            trace_clock_run   <= ctrl_q[CTRL_TRACE_BIT];
            two_wire_tdo_use  <= ctrl_q[CTRL_TDO_BIT];
        end
    end

    // Flash ECC decode; both disabled codes look the same to the flash
    always_ff @(posedge clock) begin
        if (!resetn) begin
            flash_ecc_on           <= 1'b0;
            flash_dynamic_ecc_on   <= 1'b0;
            flash_word_write_block <= 1'b0;
        end else begin
            flash_ecc_on           <= ecc_field == ECC_FULL;
            flash_dynamic_ecc_on   <= ecc_field == ECC_DYNAMIC;
            flash_word_write_block <= ecc_field == ECC_FULL;
        end
    end

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!resetn);

    sequence s_ctrl_write;
        req.wr && req.addr == OFF_CONFIG_CONTROL;
    endsequence

    sequence s_locked_ecc;
        ecc_field != ECC_OFF_OPEN;
    endsequence

    sequence s_no_unlock;
        !unlocked;
    endsequence

    sequence s_ctrl_read;
        req.rd && req.addr == OFF_CONFIG_CONTROL;
    endsequence

    sequence s_word_read;
        req.rd && req.addr == OFF_CONFIG_WORD_TWO;
    endsequence

    sequence s_status_read;
        req.rd && req.addr == OFF_STATUS;
    endsequence

    sequence s_open_ecc;
        ecc_is_writable(ecc_field);
    endsequence

    sequence s_key_write;
        req.wr && req.addr == OFF_UNLOCK_KEY;
    endsequence

    a_pll_select_follow: assert property (
        loaded_q |-> ##1 usb_pll_input_24mhz == $past(word_q[WORD_USB_PLL_SEL_BIT]))
        else $error("usb pll select does not follow config word");

    a_sleep_entry_split: assert property (
        wait_executed |=> (deep_sleep_enter ^ sleep_enter)
                          && deep_sleep_enter == $past(word_q[WORD_DEEP_SLEEP_BIT]))
        else $error("wait did not enter the selected sleep mode");

    a_watchdog_gated: assert property (
        deep_sleep_watchdog_run |->
            $past(deep_sleep_active) && $past(word_q[WORD_WDOG_EN_BIT]))
        else $error("deep sleep watchdog runs while disabled");

    a_watchdog_clock_sel: assert property (
        loaded_q |-> ##1 deep_sleep_watchdog_rc_clock == $past(word_q[WORD_WDOG_CLK_BIT]))
        else $error("watchdog clock select wrong");

    a_charge_pump_follow: assert property (
        s_ctrl_write ##1 1'b1 |=> io_charge_pump_on == $past(ctrl_q[CTRL_CHARGE_PUMP_BIT]))
        else $error("charge pump enable does not follow register");

    a_ecc_decode_one: assert property (
        ##1 (flash_ecc_on + flash_dynamic_ecc_on) <= 2'd1
            && flash_dynamic_ecc_on == ($past(ecc_field) == ECC_DYNAMIC))
        else $error("flash ecc decode wrong");

    a_ecc_field_lock: assert property (
        s_locked_ecc and s_ctrl_write |=> $stable(ecc_field))
        else $error("locked ecc field changed");

    a_ecc_word_block: assert property (
        flash_word_write_block |-> flash_ecc_on && !flash_dynamic_ecc_on)
        else $error("word writes blocked outside full ecc");

    a_debug_needs_fuse: assert property (
        debug_port_on |-> fuse_q && $past(ctrl_q[CTRL_DEBUG_BIT]))
        else $error("debug port on without fuse or enable");

    a_trace_pair_same: assert property (
        trace_outputs_on == trace_clock_run)
        else $error("trace outputs and clock disagree");

    a_trace_follow: assert property (
        loaded_q |-> ##1 trace_outputs_on == $past(ctrl_q[CTRL_TRACE_BIT]))
        else $error("trace outputs do not follow register");

    a_tdo_use_follow: assert property (
        s_ctrl_write ##1 1'b1 |=> two_wire_tdo_use == $past(ctrl_q[CTRL_TDO_BIT]))
        else $error("two wire tdo use does not follow register");

    a_protect_without_key: assert property (
        s_no_unlock and s_ctrl_write |=> $stable(ctrl_q[CTRL_DEBUG_BIT]))
        else $error("protected bit changed without unlock");

    a_unlock_one_shot: assert property (
        unlocked and s_ctrl_write |=> !unlocked)
        else $error("unlock not consumed by a control write");

    a_word_read_only: assert property (
        loaded_q && req.wr |=> $stable(word_q))
        else $error("config word changed after load");

    a_ctrl_read_data: assert property (
        s_ctrl_read |=> reg_rdata == $past(ctrl_q) ##1 reg_rdata == 32'h0000_0000 || $past(req.rd))
        else $error("control read data wrong");

    a_sleep_pulse_idle: assert property (
        !wait_executed |=> !deep_sleep_enter && !sleep_enter)
        else $error("sleep entry pulse without wait");

    a_watchdog_runs: assert property (
        deep_sleep_active && word_q[WORD_WDOG_EN_BIT] |=> deep_sleep_watchdog_run)
        else $error("deep sleep watchdog not running while enabled");

    a_pump_level: assert property (
        loaded_q |-> ##1 io_charge_pump_on == $past(ctrl_q[CTRL_CHARGE_PUMP_BIT]))
        else $error("charge pump level wrong");

    a_ecc_full_decode: assert property (
        loaded_q |-> ##1 flash_ecc_on == ($past(ecc_field) == ECC_FULL))
        else $error("flash ecc enable decode wrong");

    a_ecc_open_write: assert property (
        s_open_ecc and s_ctrl_write |=> ecc_field == $past(req.wdata[CTRL_ECC_LSB +: 2]))
        else $error("open ecc field did not take the write");

    a_word_block_follow: assert property (
        loaded_q |-> ##1 flash_word_write_block == ($past(ecc_field) == ECC_FULL))
        else $error("word write block decode wrong");

    a_debug_fuse_follow: assert property (
        loaded_q |-> ##1 debug_port_on == ($past(ctrl_q[CTRL_DEBUG_BIT]) && $past(fuse_q)))
        else $error("debug port does not follow bit and fuse");

    a_tdo_level: assert property (
        loaded_q |-> ##1 two_wire_tdo_use == $past(ctrl_q[CTRL_TDO_BIT]))
        else $error("two wire tdo level wrong");

    a_unlock_debug_write: assert property (
        unlocked and s_ctrl_write |=>
            ctrl_q[CTRL_DEBUG_BIT] == $past(req.wdata[CTRL_DEBUG_BIT]))
        else $error("unlocked write missed the protected bit");

    a_key_closes_unlock: assert property (
        unlocked and s_key_write |=> !unlocked)
        else $error("key write did not close the unlock");

    a_config_capture: assert property (
        resetn && !loaded_q |=> word_q == $past(config_word_in) && loaded_q)
        else $error("config word not captured after reset");

    a_word_read_data: assert property (
        s_word_read |=> reg_rdata == $past(word_q))
        else $error("config word read data wrong");

    a_status_read_data: assert property (
        s_status_read |=>
            reg_rdata == {29'h0, $past(loaded_q), $past(fuse_q), $past(unlocked)})
        else $error("status read data wrong");

    a_ctrl_reserved_zero: assert property (
        (ctrl_q & ~CTRL_WRITE_MASK) == 32'h0000_0000)
        else $error("unimplemented control bits set");

    a_rdata_idle: assert property (
        !req.rd |=> reg_rdata == 32'h0000_0000)
        else $error("read data stands without a read");

endmodule

`default_nettype wire

// ==== test/test_device_config_control.sv ====
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, exp, got) begin n_checks++; if ((got) !== (exp)) begin miscompares++; $display("Error %s expected %0h seen %0h", nm, exp, got); end end

module test_device_config_control;
    import dcc_pkg::*;

    localparam int LIMIT = 3000;

    logic        clock;
    logic        resetn;
    logic [7:0]  reg_addr;
    logic [31:0] reg_wdata;
    logic        reg_write;
    logic        reg_read;
    logic [31:0] reg_rdata;
    logic [31:0] config_word_in;
    logic        debug_fuse_in;
    logic        wait_executed;
    logic        deep_sleep_active;
    logic        usb_pll_input_24mhz;
    logic        deep_sleep_enter;
    logic        sleep_enter;
    logic        deep_sleep_watchdog_run;
    logic        deep_sleep_watchdog_rc_clock;
    logic        io_charge_pump_on;
    logic        flash_ecc_on;
    logic        flash_dynamic_ecc_on;
    logic        flash_word_write_block;
    logic        debug_port_on;
    logic        trace_outputs_on;
    logic        trace_clock_run;
    logic        two_wire_tdo_use;
    int          miscompares;
    int          n_checks;
    int          cycles;

    device_config_control i_device_config_control (
        .clock                        (clock),
        .resetn                       (resetn),
        .reg_addr                     (reg_addr),
        .reg_wdata                    (reg_wdata),
        .reg_write                    (reg_write),
        .reg_read                     (reg_read),
        .reg_rdata                    (reg_rdata),
        .config_word_in               (config_word_in),
        .debug_fuse_in                (debug_fuse_in),
        .wait_executed                (wait_executed),
        .deep_sleep_active            (deep_sleep_active),
        .usb_pll_input_24mhz          (usb_pll_input_24mhz),
        .deep_sleep_enter             (deep_sleep_enter),
        .sleep_enter                  (sleep_enter),
        .deep_sleep_watchdog_run      (deep_sleep_watchdog_run),
        .deep_sleep_watchdog_rc_clock (deep_sleep_watchdog_rc_clock),
        .io_charge_pump_on            (io_charge_pump_on),
        .flash_ecc_on                 (flash_ecc_on),
        .flash_dynamic_ecc_on         (flash_dynamic_ecc_on),
        .flash_word_write_block       (flash_word_write_block),
        .debug_port_on                (debug_port_on),
        .trace_outputs_on             (trace_outputs_on),
        .trace_clock_run              (trace_clock_run),
        .two_wire_tdo_use             (two_wire_tdo_use)
    );

    initial begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end

    task automatic summarize();
        $display("Checks %0d mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // A hung handshake must not stall the run
    always @(posedge clock) begin
        cycles++;
        if (cycles == LIMIT) begin
            miscompares++;
            summarize();
        end
    end

    // Idle cycle after each strobe keeps every driver to one assignment per step
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge clock);
        reg_write <= 1'b0;
        @(posedge clock);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e, input string nm);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge clock);
        reg_read <= 1'b0;
        @(negedge clock);
        `CHK(nm, e, reg_rdata)
        @(negedge clock);
        `CHK("rdata idle", 32'h0000_0000, reg_rdata)
        @(posedge clock);
    endtask

    task automatic do_reset(input logic [31:0] w, input logic f);
        resetn <= 1'b0;
        config_word_in <= w;
        debug_fuse_in <= f;
        repeat (3) @(posedge clock);
        resetn <= 1'b1;
        repeat (2) @(posedge clock);
        @(negedge clock);
    endtask

    initial begin
        logic [31:0] w;
        logic [31:0] d;
        logic [31:0] e;
        logic        f;
        logic [1:0]  c;
        resetn = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 32'h0000_0000;
        reg_write = 1'b0;
        reg_read = 1'b0;
        config_word_in = 32'h0000_0000;
        debug_fuse_in = 1'b0;
        wait_executed = 1'b0;
        deep_sleep_active = 1'b0;
        miscompares = 0;
        n_checks = 0;
        // Each pass walks one ECC code with a complementary word and fuse mix
        for (int i = 0; i < 4; i++) begin
            w = i[0] ? 32'h5800_1234 : 32'hA400_00FF;
            f = i[1] ^ i[0];
            c = i[1:0];
            d = {24'h00_0000, i[0], 1'b0, c, 1'b0, ~i[0], 1'b1, i[1]};
            e = {24'h00_0000, i[0], 1'b0, c, 1'b1, ~i[0], 1'b0, i[1]};
            do_reset(w, f);
            `CHK("usb pll 24mhz", w[30], usb_pll_input_24mhz)
            `CHK("watchdog rc clock", w[26], deep_sleep_watchdog_rc_clock)
            `CHK("debug port", f, debug_port_on)
            `CHK("charge pump", 1'b0, io_charge_pump_on)
            `CHK("trace out", 1'b0, trace_outputs_on)
            @(posedge clock);
            deep_sleep_active <= 1'b1;
            repeat (2) @(posedge clock);
            @(negedge clock);
            `CHK("watchdog run", w[27], deep_sleep_watchdog_run)
            @(posedge clock);
            deep_sleep_active <= 1'b0;
            wait_executed <= 1'b1;
            @(posedge clock);
            wait_executed <= 1'b0;
            @(negedge clock);
            `CHK("deep sleep enter", w[28], deep_sleep_enter)
            `CHK("sleep enter", ~w[28], sleep_enter)
            @(negedge clock);
            `CHK("enter pulse end", 2'b00, {deep_sleep_enter, sleep_enter})
            `CHK("watchdog idle", 1'b0, deep_sleep_watchdog_run)
            @(posedge clock);
            rd(OFF_CONFIG_WORD_TWO, w, "config word");
            wr(OFF_CONFIG_WORD_TWO, ~w);
            config_word_in <= ~w;
            rd(OFF_CONFIG_WORD_TWO, w, "config word kept");
            rd(OFF_CONFIG_CONTROL, CONFIG_CONTROL_RESET, "control reset");
            wr(OFF_STATUS, 32'h0000_0000);
            rd(OFF_STATUS, {29'h0, 1'b1, f, 1'b0}, "status");
            rd(8'h10, 32'h0000_0000, "unmapped");
            wr(OFF_CONFIG_CONTROL, d);
            @(negedge clock);
            `CHK("charge pump", i[0], io_charge_pump_on)
            `CHK("trace out", ~i[0], trace_outputs_on)
            `CHK("trace clock", ~i[0], trace_clock_run)
            `CHK("tdo use", i[1], two_wire_tdo_use)
            `CHK("ecc on", c == 2'h0, flash_ecc_on)
            `CHK("dynamic ecc", c == 2'h1, flash_dynamic_ecc_on)
            `CHK("word block", c == 2'h0, flash_word_write_block)
            `CHK("debug kept", f, debug_port_on)
            @(posedge clock);
            rd(OFF_CONFIG_CONTROL, e, "control");
            wr(OFF_CONFIG_CONTROL, d | 32'h0000_0030);
            rd(OFF_CONFIG_CONTROL, e, "ecc lock");
            wr(OFF_UNLOCK_KEY, UNLOCK_KEY_ONE);
            wr(OFF_UNLOCK_KEY, UNLOCK_KEY_TWO);
            rd(OFF_STATUS, {29'h0, 1'b1, f, 1'b1}, "unlocked");
            wr(OFF_CONFIG_CONTROL, d);
            e[3] = 1'b0;
            @(negedge clock);
            `CHK("debug cleared", 1'b0, debug_port_on)
            @(posedge clock);
            rd(OFF_CONFIG_CONTROL, e, "unlocked write");
            wr(OFF_UNLOCK_KEY, UNLOCK_KEY_TWO);
            wr(OFF_UNLOCK_KEY, UNLOCK_KEY_ONE);
            wr(OFF_CONFIG_CONTROL, d | 32'h0000_0008);
            rd(OFF_CONFIG_CONTROL, e, "bad key order");
            @(negedge clock);
            `CHK("debug still off", 1'b0, debug_port_on)
            @(posedge clock);
        end
        summarize();
    end
endmodule

`default_nettype wire
